// ===== rtl/bwd_pkg.sv
// Package for the board watchdog timer: widths, timing constants, carriers.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
package bwd_pkg;

    // Time-out value width (unsigned binary count)
    localparam int unsigned CNT_W        = 8;
    // Clock rate in kHz
    localparam int unsigned CLK_KHZ      = 250000;
    // Unit periods in milliseconds
    localparam int unsigned UNIT_SEC_MS  = 1000;
    localparam int unsigned UNIT_MIN_MS  = 60000;
    // Default clock cycles per unit (seconds and minutes)
    localparam int unsigned SEC_CYCLES   = CLK_KHZ * UNIT_SEC_MS;
    localparam longint unsigned MIN_CYCLES_L =
        64'(CLK_KHZ) * 64'(UNIT_MIN_MS);
    // Prescaler width, wide enough for the minute count
    localparam int unsigned PRE_W        = 34;
    // Reset pulse counter start; the issued pulse lasts this plus one cycles
    localparam logic [3:0]  RST_PULSE    = 4'hF;
    // Zero value of a time-out
    localparam logic [CNT_W-1:0] TMO_ZERO = 8'h00;

    // Unit selection
    typedef enum logic {
        BWD_UNIT_SEC,
        BWD_UNIT_MIN
    } bwd_unit_e;

    // Load request from the firmware service path
    typedef struct packed {
        logic             valid;
        logic [CNT_W-1:0] value;
    } bwd_load_s;

    // Watchdog state
    typedef enum logic [1:0] {
        BWD_OFF,
        BWD_RUN,
        BWD_FIRE
    } bwd_state_e;

endpackage : bwd_pkg

// ===== rtl/bwd_tick.sv
// Unit tick generator for the board watchdog timer.
// Assumes restart is pulsed on every load so a unit starts whole.
`timescale 1ns/1ps
`default_nettype none
module bwd_tick
    import bwd_pkg::*;
#(
    parameter logic [PRE_W-1:0] SEC_DIV = PRE_W'(SEC_CYCLES),
    parameter logic [PRE_W-1:0] MIN_DIV = PRE_W'(MIN_CYCLES_L)
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       restart,
    input  wire logic       run,
    input  wire bwd_unit_e  unit,
    // Output
    output logic            tick
);

    logic [PRE_W-1:0] pre_ff;    // Cycles left in current unit
    logic [PRE_W-1:0] nxt_pre;
    logic             tick_ff;   // Registered unit pulse
    logic             nxt_tick;
    logic [PRE_W-1:0] div_val;   // Selected division

    // Division by selected unit
    assign div_val = (unit == BWD_UNIT_MIN) ? MIN_DIV : SEC_DIV;

    // Next prescaler value
    always_comb begin
        nxt_pre  = pre_ff;
        nxt_tick = 1'b0;
        if (restart || !run) begin
            // Fresh unit on every load; idle when stopped
            nxt_pre = div_val - PRE_W'(1);
        end else if (pre_ff == '0) begin
            nxt_pre  = div_val - PRE_W'(1);
            nxt_tick = 1'b1;
        end else begin
            nxt_pre = pre_ff - PRE_W'(1);
        end
    end

    // Prescaler registers
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            pre_ff  <= nxt_pre;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : bwd_tick
`default_nettype wire

// ===== rtl/bwd_core.sv
// Board watchdog timer: loadable down counter that resets the system.
// Assumes loads arrive as single-cycle requests on the board clock.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Nonzero load starts countdown per unit
// - Reaching zero issues system reset
// - Zero load disables watchdog
// - Unit is seconds unless otherwise selected
module bwd_core
    import bwd_pkg::*;
#(
    parameter logic [PRE_W-1:0] SEC_DIV = PRE_W'(SEC_CYCLES),
    parameter logic [PRE_W-1:0] MIN_DIV = PRE_W'(MIN_CYCLES_L)
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Firmware load request
    input  wire bwd_load_s  load,
    // Unit selection from setup
    input  wire bwd_unit_e  unit_sel,
    // Status
    output logic            running,
    output logic [CNT_W-1:0] count,
    // System reset request
    output logic            sys_reset
);

    // State, count and pulse registers with their next values
    bwd_state_e       state_ff;    // Watchdog state
    bwd_state_e       nxt_state;
    logic [CNT_W-1:0] cnt_ff;      // Remaining units
    logic [CNT_W-1:0] nxt_cnt;
    logic [3:0]       pls_ff;      // Reset pulse length counter
    logic [3:0]       nxt_pls;
    logic             rst_out_ff;  // Registered reset output
    logic             nxt_rst_out;
    logic             tick;        // One unit elapsed
    logic             restart;     // Any load restarts the unit

    // Cycles the reset pulse stays high after its first sampled edge
    localparam int PLS_HOLD = RST_PULSE;

    // A load always restarts the unit prescaler, so a reload never
    // inherits a partly used unit from the count it replaces.
    assign restart = load.valid;

    // Unit tick source
    // unit select
    bwd_tick #(
        .SEC_DIV (SEC_DIV),
        .MIN_DIV (MIN_DIV)
    ) u_tick (
        .clk     (clk),
        .rst     (rst),
        .restart (restart),
        .run     (running),
        .unit    (unit_sel),
        .tick    (tick)
    );

    // Next state and count
    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_pls     = pls_ff;
        nxt_rst_out = 1'b0;
        case (state_ff)
            BWD_OFF, BWD_RUN: begin
                if (load.valid) begin
                    nxt_cnt = load.value;
                    nxt_state = (load.value == TMO_ZERO) ? BWD_OFF
                                                         : BWD_RUN;
                end else if (running && tick) begin
                    // One unit gone; a load in the same cycle wins instead
                    nxt_cnt = cnt_ff - CNT_W'(1);
                    if (cnt_ff == CNT_W'(1)) begin
                        nxt_state   = BWD_FIRE;
                        nxt_pls     = RST_PULSE;
                        nxt_rst_out = 1'b1;
                    end
                end
            end
            BWD_FIRE: begin
                // Hold reset for a fixed pulse, then stay off
                // Loads are dropped here: the system is being reset and
                // a new count would only outlive the pulse by accident
                nxt_rst_out = 1'b1;
                if (pls_ff == 4'h0) begin
                    nxt_rst_out = 1'b0;
                    nxt_state   = BWD_OFF;
                end else begin
                    nxt_pls = pls_ff - 4'h1;
                end
            end
            default: begin
                // Unused encoding falls back to the safe disabled state
                nxt_state = BWD_OFF;
            end
        endcase
    end

    // State registers
    // Synchronous reset; no clock enable, every edge updates
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff   <= BWD_OFF;
            cnt_ff     <= TMO_ZERO;
            pls_ff     <= 4'h0;
            rst_out_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            pls_ff     <= nxt_pls;
            rst_out_ff <= nxt_rst_out;
        end
    end

    // Run flag decoded once from the state register
    assign running   = (state_ff == BWD_RUN);
    // Remaining units straight from the counter register
    assign count     = cnt_ff;
    // Reset request comes from a flip-flop so it never glitches
    assign sys_reset = rst_out_ff;

    // Checks below watch the design's own outputs and the unit tick.
    // Each is stopped by the synchronous reset so that the cycles
    // spent in reset never count as a violation; a_reset_off
    // looks at reset itself and so has no disable.

    // Zero load stops the watchdog
    a_zero_disables: assert property (@(posedge clk) disable iff (rst)
        load.valid && load.value == TMO_ZERO
        |=> !running)
        else $error("zero load did not disable");

    // Nonzero load runs with that count
    // The reset pulse refuses loads, so it is left out here
    a_load_starts: assert property (@(posedge clk) disable iff (rst)
        load.valid && load.value != TMO_ZERO && !sys_reset
        |=> running && count == $past(load.value))
        else $error("nonzero load did not start");

    // Last tick raises reset next cycle
    a_expiry_reset: assert property (@(posedge clk) disable iff (rst)
        running && tick && !load.valid && count == 8'h01
        |=> sys_reset && count == TMO_ZERO)
        else $error("expiry did not reset");

    // Reset only after expiry
    a_reset_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(sys_reset)
        |-> $past(running) && $past(tick))
        else $error("spurious reset");

    // Disabled watchdog never resets
    // An idle watchdog must stay harmless to the board
    a_off_quiet: assert property (@(posedge clk) disable iff (rst)
        !running && !sys_reset
        |=> !$rose(sys_reset))
        else $error("reset while disabled");

    // Count steps down by one per tick
    a_count_step: assert property (@(posedge clk) disable iff (rst)
        running && tick && !load.valid && count > 8'h01
        |=> running && count == $past(count) - 8'h01)
        else $error("count step wrong");

    // Count holds between ticks
    // A tick-free cycle must not leak a decrement
    a_count_hold: assert property (@(posedge clk) disable iff (rst)
        running && !tick && !load.valid
        |=> count == $past(count))
        else $error("count moved without tick");

    // Off after reset release
    a_reset_off: assert property (@(posedge clk)
        rst
        |=> !running && !sys_reset && count == TMO_ZERO)
        else $error("not disabled after reset");

    // Pulse has a fixed length, then drops
    // A reset request that ended early could leave the board half reset
    a_pulse_length: assert property (@(posedge clk) disable iff (rst)
        $rose(sys_reset)
        |-> ##PLS_HOLD sys_reset ##1 !sys_reset)
        else $error("reset pulse length wrong");

    // A load during the pulse is dropped; count stays put and the watchdog does not run
    a_fire_drops: assert property (@(posedge clk) disable iff (rst)
        sys_reset && load.valid
        |=> !running && count == $past(count))
        else $error("load taken during reset pulse");

    // Disabled and quiet: nothing moves until a load
    a_off_hold: assert property (@(posedge clk) disable iff (rst)
        !running && !sys_reset && !load.valid
        |=> !running && !sys_reset && count == $past(count))
        else $error("disabled watchdog changed");

    // A running count is never zero
    // Zero while running would mean a missed expiry
    a_run_nonzero: assert property (@(posedge clk) disable iff (rst)
        running
        |-> count != TMO_ZERO)
        else $error("running with zero count");

    // After the pulse the watchdog stays off with an empty count
    a_expiry_off: assert property (@(posedge clk) disable iff (rst)
        $fell(sys_reset)
        |-> !running && count == TMO_ZERO)
        else $error("not off after reset pulse");

endmodule : bwd_core
`default_nettype wire

// ===== dv/tb_top.sv
// Bench for the board watchdog core: table rows, then corner cases.
// Assumes short unit dividers so every countdown ends quickly.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import bwd_pkg::*;
;
    // Short dividers: seconds 4 cycles, minutes 8 cycles
    localparam int SD = 4;
    localparam int MD = 8;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    bwd_load_s        load = '0;
    bwd_unit_e        unit_sel = BWD_UNIT_SEC;
    logic             running;
    logic [CNT_W-1:0] count;
    logic             sys_reset;
    int               err_total = 0;
    int               checks = 0;
    int               cyc = 0;
    int               n;
    int               e;
    // Rows of {unit, value, cycles from load to reset}; zero never fires
    logic [20:0]      rows [5] = '{21'h001005, 21'h00300D, 21'h102011,
                                   21'h000000, 21'h0FF3FD};

    bwd_core #(.SEC_DIV(PRE_W'(SD)), .MIN_DIV(PRE_W'(MD))) dut (
        .clk(clk), .rst(rst), .load(load), .unit_sel(unit_sel),
        .running(running), .count(count), .sys_reset(sys_reset));

    // Free-running 250 MHz clock
    always #2 clk = ~clk;

    // Hang guard: far above the longest expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    task chk(input logic [7:0] seen, input logic [7:0] want);
        checks = checks + 1;
        if (seen !== want) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0t saw %h want %h", $time, seen, want);
        end
    endtask : chk

    task finish_test();
        if (err_total == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // One-cycle load; returns just after the taking edge
    task do_load(input logic [7:0] v);
        @(posedge clk);
        load <= '{valid: 1'b1, value: v};
        @(posedge clk);
        load.valid <= 1'b0;
        #1;
    endtask : do_load

    // Cycles until the reset request shows, bounded
    task wait_fire(output int c);
        c = 0;
        while (sys_reset !== 1'b1 && c < 1100) begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask : wait_fire

    // Length of the reset request pulse, bounded
    task pulse_len(output int c);
        c = 0;
        while (sys_reset === 1'b1 && c < 40) begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask : pulse_len

    // Expiry must land on the exact expected cycle
    task chk_fire(input int c, input int x);
        chk({7'h00, c == x}, 8'h01);
    endtask : chk_fire

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(count, TMO_ZERO);
        chk({6'h00, running, sys_reset}, 8'h00);
        foreach (rows[i]) begin
            @(posedge clk);
            unit_sel <= bwd_unit_e'(rows[i][20]);
            do_load(rows[i][19:12]);
            chk(count, rows[i][19:12]);
            chk({7'h00, running}, {7'h00, rows[i][19:12] != 8'h00});
            if (rows[i][19:12] == 8'h00) begin
                repeat (40) @(posedge clk);
                #1;
                chk({7'h00, sys_reset}, 8'h00);
            end else begin
                e = int'(rows[i][11:0]);
                wait_fire(n);
                chk_fire(n, e);
                pulse_len(n);
                chk(8'(n), 8'(RST_PULSE) + 8'h01);
                chk({7'h00, running}, 8'h00);
            end
        end
        // Reload mid-count restarts the full period
        do_load(8'h02);
        repeat (6) @(posedge clk);
        do_load(8'h02);
        wait_fire(n);
        chk_fire(n, 2 * SD + 1);
        pulse_len(n);
        // Zero load mid-count stops it
        do_load(8'h03);
        repeat (5) @(posedge clk);
        do_load(8'h00);
        repeat (40) @(posedge clk);
        #1;
        chk({running, sys_reset, 6'h00}, 8'h00);
        // Load during the pulse is ignored
        do_load(8'h01);
        wait_fire(n);
        do_load(8'h05);
        pulse_len(n);
        chk(8'(n), 8'(RST_PULSE) - 8'h01);
        chk({7'h00, running}, 8'h00);
        // reloads with a wide margin inside the period
        for (int k = 0; k < 4; k++) begin
            do_load(8'h03);
            repeat (6) @(posedge clk);
            #1;
            chk({6'h00, running, sys_reset}, 8'h02);
        end
        // zero load before the program leaves
        do_load(8'h00);
        repeat (40) @(posedge clk);
        #1;
        chk({6'h00, running, sys_reset}, 8'h00);
        // Reset in mid-count leaves it off
        do_load(8'h03);
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({running, sys_reset, 6'h00}, 8'h00);
        chk(count, TMO_ZERO);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
